//--- src/gpra_pkg.sv
// constants and types shared by the register-number translation block
package gpra_pkg;
	localparam int NUM_W = 8;
	localparam int WORD_W = 32;
	localparam int MASK_W = 16;
	localparam int OPS = 3;
	localparam int FILE_DEPTH = 256;
	localparam int SP_LO = 2;
	localparam int SP_HI = 8;
	localparam int MTSR_LO = 2;
	localparam int MTSR_HI = 9;
	localparam int BANK_LO = 4;
	localparam logic [7:0] SP_REG_NUM = 8'h01;
	localparam logic [7:0] INDIRECT_NUM = 8'h00;
	localparam logic [7:0] BANK0_FIRST = 8'h02;
	localparam logic [7:0] SPR_BANK_MASK = 8'h07;
	localparam logic [7:0] SPR_PTR_C = 8'h80;
	localparam logic [7:0] SPR_PTR_A = 8'h81;
	localparam logic [7:0] SPR_PTR_B = 8'h82;
	localparam logic [7:0] SPR_FIRST_OPEN = 8'h80;
	localparam logic [7:0] SPR_LAST_OPEN = 8'h9F;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [31:0] SP_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef logic [NUM_W-1:0] gpra_num_t;
	typedef logic [WORD_W-1:0] gpra_word_t;
	typedef logic [MASK_W-1:0] gpra_mask_t;
endpackage

//--- src/gpra_xl_if.sv
// carrier between the top and one register-number translator
`timescale 1ns/1ps
interface gpra_xl_if;
	import gpra_pkg::*;
	gpra_num_t num;
	gpra_num_t ptr;
	logic [6:0] sp_off;
	gpra_mask_t mask;
	logic user;
	gpra_num_t abs_num;
	logic viol;
	modport xl (input num, ptr, sp_off, mask, user, output abs_num, viol);
	modport ctl (output num, ptr, sp_off, mask, user, input abs_num, viol);
endinterface

//--- src/gpra_xlate.sv
// one operand: register number to absolute number plus bank check
`timescale 1ns/1ps
module gpra_xlate
	import gpra_pkg::*;
(
	gpra_xl_if.xl xi // translation request and answer
);
	logic [6:0] local_sum;
	always_comb
	begin
		local_sum = xi.num[6:0] + xi.sp_off;
		if (xi.num[7])
			xi.abs_num = {1'b1, local_sum};
		else if (xi.num == INDIRECT_NUM)
			xi.abs_num = xi.ptr; // pointer holds absolute, no add
		else
			xi.abs_num = xi.num;
	end
	// banks are absolute 16-number groups; 0 and 1 sit outside bank 0
	always_comb
	begin
		xi.viol = xi.user && xi.mask[xi.abs_num[7:BANK_LO]]
			&& (xi.abs_num >= BANK0_FIRST);
	end
endmodule // gpra_xlate

//--- src/gpra_regmem.sv
// general-purpose register storage, two registered reads, one write
`timescale 1ns/1ps
module gpra_regmem
	import gpra_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH,
	parameter int WIDTH = WORD_W
)
(
	input wire logic clk, // clock
	input wire logic ce, // clock enable
	input wire logic [7:0] rd_a_addr, // read port a address
	input wire logic [7:0] rd_b_addr, // read port b address
	input wire logic wr_en, // write strobe
	input wire logic [7:0] wr_addr, // write address
	input wire logic [WIDTH-1:0] wr_data, // write data
	output logic [WIDTH-1:0] rd_a_data, // read port a data
	output logic [WIDTH-1:0] rd_b_data // read port b data
);
	logic [WIDTH-1:0] mem [DEPTH];
	// no reset: contents are software state, unimplemented slots undefined
	always_ff @(posedge clk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			rd_a_data <= mem[rd_a_addr];
			rd_b_data <= mem[rd_b_addr];
		end
	end
endmodule // gpra_regmem

//--- src/gpra_top.sv
// register-number translation, bank protection and operand fetch
// Operation
// - 192 registers: 64 global, 128 local by MSB
// - two sources and one result per instruction
// - top bit zero: global, absolute equals number
// - unimplemented globals 2-63 still bank checked
// - number zero takes field's own indirect pointer
// - shadow stack pointer updated by arithmetic/logical only
// - local: add stack pointer bits 8-2, keep MSB
// - sixteen banks of sixteen; bank 0 from 2
// - mask bit n guards bank n
// - user access to masked bank traps
// - check absolute number after stack-pointer add
// - supervisor mode ignores the bank mask
// - three absolute 8-bit pointers, no stack add
// - special move loads pointer from bits 9-2
// - special-move pointer write takes effect late
// - group instructions load all three pointers together
// - group-loaded pointers checked; special move not checked (here a group-loaded pointer is checked only if its ISSUE_USE bit is set)
// - special registers reached by explicit moves only
// - supervisor flag one: supervisor; zero: user
`timescale 1ns/1ps
module gpra_top
	import gpra_pkg::*;
(
	input wire logic SYS_CLK, // clock
	input wire logic RST, // async reset, high
	input wire logic CE, // clock enable
	input wire logic SUPERVISOR_FLAG, // current mode bit
	input wire logic ISSUE_VALID, // instruction issued
	input wire gpra_num_t ISSUE_FIELD_A, // source a number
	input wire gpra_num_t ISSUE_FIELD_B, // source b number
	input wire gpra_num_t ISSUE_FIELD_C, // result number
	input wire logic [2:0] ISSUE_USE, // fields named: c,b,a
	input wire logic ISSUE_LOAD_PTRS, // group pointer load
	input wire logic SPR_WR, // move to special register
	input wire logic SPR_RD, // move from special register
	input wire gpra_num_t SPR_NUM, // special register number
	input wire gpra_word_t SPR_WDATA, // move source operand
	input wire logic WB_VALID, // result write
	input wire logic WB_ARITH, // result from arith/logical
	input wire gpra_num_t WB_ABS, // absolute result number
	input wire gpra_word_t WB_DATA, // result data
	output gpra_num_t ABS_A, // absolute source a
	output gpra_num_t ABS_B, // absolute source b
	output gpra_num_t ABS_C, // absolute result
	output logic ABS_VALID, // absolute numbers valid
	output logic PROT_TRAP, // bank protection violation
	output gpra_word_t OPER_A_DATA, // source a contents
	output gpra_word_t OPER_B_DATA, // source b contents
	output gpra_word_t SPR_RDATA, // special register read
	output logic SPR_TRAP // user access to protected
);
	gpra_num_t field [OPS];
	gpra_num_t ptr [OPS];
	gpra_num_t ptr_pend_val [OPS];
	logic [OPS-1:0] ptr_pend;
	gpra_num_t next_abs [OPS];
	logic [OPS-1:0] viol;
	gpra_mask_t gpr_bank_user_protect_mask;
	gpra_word_t sp_shadow;
	logic user_mode;
	logic spr_protected;
	logic [1:0] spr_ptr_idx;
	logic spr_is_ptr;
	logic [6:0] hlp_loc_a;

	assign user_mode = !SUPERVISOR_FLAG;
	assign field[0] = ISSUE_FIELD_A;
	assign field[1] = ISSUE_FIELD_B;
	assign field[2] = ISSUE_FIELD_C;

	// one translator per operand position
	for (genvar g = 0; g < OPS; g++)
	begin : g_xl
		gpra_xl_if xi ();
		assign xi.num = field[g];
		assign xi.ptr = ptr[g];
		assign xi.sp_off = sp_shadow[SP_HI:SP_LO];
		assign xi.mask = gpr_bank_user_protect_mask;
		assign xi.user = user_mode;
		assign next_abs[g] = xi.abs_num;
		assign viol[g] = xi.viol && ISSUE_USE[g];
		gpra_xlate u_xl (
			.xi(xi)
		);
	end

	// storage indexed by absolute numbers
	gpra_regmem #(
		.DEPTH(FILE_DEPTH),
		.WIDTH(WORD_W)
	) u_mem (
		.clk(SYS_CLK),
		.ce(CE),
		.rd_a_addr(next_abs[0]),
		.rd_b_addr(next_abs[1]),
		.wr_en(WB_VALID),
		.wr_addr(WB_ABS),
		.wr_data(WB_DATA),
		.rd_a_data(OPER_A_DATA),
		.rd_b_data(OPER_B_DATA)
	);

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			ABS_A <= PTR_RESET;
			ABS_B <= PTR_RESET;
			ABS_C <= PTR_RESET;
			ABS_VALID <= 1'b0;
			PROT_TRAP <= 1'b0;
		end
		else if (CE)
		begin
			ABS_A <= next_abs[0];
			ABS_B <= next_abs[1];
			ABS_C <= next_abs[2];
			ABS_VALID <= ISSUE_VALID;
			// group-loaded values are the translated fields, so those named in
			// ISSUE_USE are checked here; later special moves bypass this check
			PROT_TRAP <= ISSUE_VALID && (|viol);
		end
	end

	// shadow only follows arithmetic/logical results to register 1
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			sp_shadow <= SP_RESET;
		else if (CE && WB_VALID && WB_ARITH && WB_ABS == SP_REG_NUM)
			sp_shadow <= WB_DATA;
	end

	// special-register decode; only explicit moves reach these
	assign spr_protected = SPR_NUM < SPR_FIRST_OPEN
		|| SPR_NUM > SPR_LAST_OPEN;
	always_comb
	begin
		spr_is_ptr = 1'b1;
		if (SPR_NUM == SPR_PTR_A)
			spr_ptr_idx = 2'd0;
		else if (SPR_NUM == SPR_PTR_B)
			spr_ptr_idx = 2'd1;
		else if (SPR_NUM == SPR_PTR_C)
			spr_ptr_idx = 2'd2;
		else
		begin
			spr_ptr_idx = 2'd0;
			spr_is_ptr = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			gpr_bank_user_protect_mask <= MASK_RESET;
		else if (CE && SPR_WR && !user_mode && SPR_NUM == SPR_BANK_MASK)
			gpr_bank_user_protect_mask <= SPR_WDATA[MASK_W-1:0];
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			SPR_RDATA <= WORD_ZERO;
			SPR_TRAP <= 1'b0;
		end
		else if (CE)
		begin
			SPR_TRAP <= (SPR_WR || SPR_RD) && user_mode && spr_protected;
			if (SPR_RD && !(user_mode && spr_protected))
			begin
				if (SPR_NUM == SPR_BANK_MASK)
					SPR_RDATA <= {16'h0000, gpr_bank_user_protect_mask};
				else if (spr_is_ptr)
					SPR_RDATA <= {22'h00_0000, ptr[spr_ptr_idx], 2'b00};
				else
					SPR_RDATA <= WORD_ZERO;
			end
		end
	end

	// pointers: group load wins, a special move is staged and only
	// committed after the next instruction has used the old value,
	// so the second instruction after the move sees it
	for (genvar p = 0; p < OPS; p++)
	begin : g_ptr
		logic spr_hit;
		assign spr_hit = SPR_WR && spr_is_ptr && spr_ptr_idx == 2'(p);
		always_ff @(posedge SYS_CLK or posedge RST)
		begin
			if (RST)
			begin
				ptr[p] <= PTR_RESET;
				ptr_pend[p] <= 1'b0;
				ptr_pend_val[p] <= PTR_RESET;
			end
			else if (CE)
			begin
				if (ISSUE_VALID && ISSUE_LOAD_PTRS)
				begin
					ptr[p] <= next_abs[p];
					ptr_pend[p] <= 1'b0;
				end
				else if (spr_hit)
				begin
					ptr_pend[p] <= 1'b1;
					ptr_pend_val[p] <= SPR_WDATA[MTSR_HI:MTSR_LO];
					if (ISSUE_VALID && ptr_pend[p])
						ptr[p] <= ptr_pend_val[p];
				end
				else if (ISSUE_VALID && ptr_pend[p])
				begin
					ptr[p] <= ptr_pend_val[p];
					ptr_pend[p] <= 1'b0;
				end
			end
		end
	end

	assign hlp_loc_a = ISSUE_FIELD_A[6:0] + sp_shadow[SP_HI:SP_LO];

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_sup_no_trap;
		ISSUE_VALID && CE && SUPERVISOR_FLAG |=> !PROT_TRAP;
	endproperty
	a_sup_no_trap: assert property (p_sup_no_trap)
		else $error("bank trap raised in supervisor mode");

	property p_global_direct;
		ISSUE_VALID && CE && !ISSUE_FIELD_A[7] && ISSUE_FIELD_A != INDIRECT_NUM
			|=> ABS_A == $past(ISSUE_FIELD_A);
	endproperty
	a_global_direct: assert property (p_global_direct)
		else $error("global number not passed unchanged");

	property p_local_add;
		ISSUE_VALID && CE && ISSUE_FIELD_A[7]
			|=> ABS_A[7] && ABS_A[6:0] == $past(hlp_loc_a);
	endproperty
	a_local_add: assert property (p_local_add)
		else $error("local number not offset by stack pointer");

	property p_indirect;
		ISSUE_VALID && CE && ISSUE_FIELD_A == INDIRECT_NUM
			|=> ABS_A == $past(ptr[0]);
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("indirect access did not use pointer a");

	property p_trap_cause;
		ISSUE_VALID && CE && user_mode && ISSUE_USE[1]
			&& gpr_bank_user_protect_mask[next_abs[1][7:BANK_LO]]
			&& next_abs[1] >= BANK0_FIRST |=> PROT_TRAP;
	endproperty
	a_trap_cause: assert property (p_trap_cause)
		else $error("protected bank access did not trap");

	property p_sp_hold;
		CE && !(WB_VALID && WB_ARITH) |=> $stable(sp_shadow);
	endproperty
	a_sp_hold: assert property (p_sp_hold)
		else $error("shadow stack pointer changed without arith write");

	property p_mtsr_late;
		SPR_WR && CE && !ISSUE_VALID && SPR_NUM == SPR_PTR_A
			|=> ptr_pend[0] && ptr[0] == $past(ptr[0])
			&& ptr_pend_val[0] == $past(SPR_WDATA[MTSR_HI:MTSR_LO]);
	endproperty
	a_mtsr_late: assert property (p_mtsr_late)
		else $error("special move pointer write wrong or too early");

	property p_commit_second;
		ISSUE_VALID && CE && !ISSUE_LOAD_PTRS && ptr_pend[1] && !SPR_WR
			|=> ptr[1] == $past(ptr_pend_val[1]) && !ptr_pend[1];
	endproperty
	a_commit_second: assert property (p_commit_second)
		else $error("staged pointer not committed after one instruction");

	property p_group_load;
		ISSUE_VALID && CE && ISSUE_LOAD_PTRS |=> ptr[2] == $past(next_abs[2]);
	endproperty
	a_group_load: assert property (p_group_load)
		else $error("group load did not set result pointer");

	property p_spr_trap;
		CE && (SPR_WR || SPR_RD) && !SUPERVISOR_FLAG
			&& (SPR_NUM < SPR_FIRST_OPEN || SPR_NUM > SPR_LAST_OPEN)
			|=> SPR_TRAP;
	endproperty
	a_spr_trap: assert property (p_spr_trap)
		else $error("user move to protected special register not trapped");

	// a refused user write must leave the bank mask untouched
	property p_mask_user_hold;
		CE && SPR_WR && !SUPERVISOR_FLAG
			|=> $stable(gpr_bank_user_protect_mask);
	endproperty
	a_mask_user_hold: assert property (p_mask_user_hold)
		else $error("bank mask changed by a user-mode move");

	c_user_trap: cover property (ABS_VALID && PROT_TRAP);
	c_local: cover property (ISSUE_VALID && CE && ISSUE_FIELD_A[7]);
	c_mtsr_use: cover property (SPR_WR && SPR_NUM == SPR_PTR_A
		##2 ISSUE_VALID ##2 ISSUE_VALID && ISSUE_FIELD_A == INDIRECT_NUM);
	c_group_user: cover property (ISSUE_VALID && CE && ISSUE_LOAD_PTRS
		&& !SUPERVISOR_FLAG);
endmodule // gpra_top

//--- tb/gpra_pipe_model.sv
// pipeline-side model: issues, special moves and result writes
`timescale 1ns/1ps
module gpra_pipe_model (
	input wire logic clk, // clock
	output logic issue_valid, // issue strobe
	output gpra_pkg::gpra_num_t fa, // source a field
	output gpra_pkg::gpra_num_t fb, // source b field
	output gpra_pkg::gpra_num_t fc, // result field
	output logic [2:0] use_f, // fields named
	output logic load_ptrs, // group pointer load
	output logic spr_wr, // move to special
	output logic spr_rd, // move from special
	output gpra_pkg::gpra_num_t spr_num, // special number
	output gpra_pkg::gpra_word_t spr_wdata, // move source
	output logic wb_valid, // result write
	output logic wb_arith, // arith/logical result
	output gpra_pkg::gpra_num_t wb_abs, // write target
	output gpra_pkg::gpra_word_t wb_data // write data
);
	import gpra_pkg::*;
	initial
	begin
		{issue_valid, load_ptrs, spr_wr, spr_rd, wb_valid} <= 5'h00;
		{fa, fb, fc, spr_num, wb_abs} <= 40'h00_0000_0000;
		{use_f, wb_arith} <= 4'h0;
		{spr_wdata, wb_data} <= 64'h0000_0000_0000_0000;
	end
	// released fields flip so nothing can lean on a stale value
	task automatic issue(input gpra_num_t a, input gpra_num_t b,
		input gpra_num_t c, input logic [2:0] u, input logic ld);
		@(posedge clk);
		{issue_valid, load_ptrs, use_f} <= {1'h1, ld, u};
		{fa, fb, fc} <= {a, b, c};
		@(posedge clk);
		{issue_valid, load_ptrs} <= 2'h0;
		{fa, fb, fc} <= ~{a, b, c};
	endtask
	task automatic spr(input logic rd, input gpra_num_t n, input gpra_word_t d);
		@(posedge clk);
		{spr_wr, spr_rd, spr_num, spr_wdata} <= {~rd, rd, n, d};
		@(posedge clk);
		{spr_wr, spr_rd, spr_num, spr_wdata} <= {2'h0, ~n, ~d};
	endtask
	task automatic wb(input logic ar, input gpra_num_t n, input gpra_word_t d);
		@(posedge clk);
		{wb_valid, wb_arith, wb_abs, wb_data} <= {1'h1, ar, n, d};
		@(posedge clk);
		{wb_valid, wb_abs, wb_data} <= {1'h0, ~n, ~d};
	endtask
endmodule // gpra_pipe_model

//--- tb/gpra_tb_top.sv
// self-checking bench for the register-number translation block
`timescale 1ns/1ps
module gpra_tb_top;
	import gpra_pkg::*;
	logic sys_clk, rst, ce, sup, iv, ldp, sw, sr, wv, wa;
	logic abs_valid, prot_trap, spr_trap;
	logic [2:0] uf;
	gpra_num_t fa, fb, fc, sn, wab, abs_a, abs_b, abs_c;
	gpra_word_t swd, wd, oa, ob, srd;
	gpra_num_t p [3];
	int fails, cmp_count;
	gpra_pipe_model pipe (.clk(sys_clk), .issue_valid(iv), .fa(fa), .fb(fb),
		.fc(fc), .use_f(uf), .load_ptrs(ldp), .spr_wr(sw), .spr_rd(sr),
		.spr_num(sn), .spr_wdata(swd), .wb_valid(wv), .wb_arith(wa),
		.wb_abs(wab), .wb_data(wd));
	gpra_top DUT (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
		.SUPERVISOR_FLAG(sup), .ISSUE_VALID(iv), .ISSUE_FIELD_A(fa),
		.ISSUE_FIELD_B(fb), .ISSUE_FIELD_C(fc), .ISSUE_USE(uf),
		.ISSUE_LOAD_PTRS(ldp), .SPR_WR(sw), .SPR_RD(sr), .SPR_NUM(sn),
		.SPR_WDATA(swd), .WB_VALID(wv), .WB_ARITH(wa), .WB_ABS(wab),
		.WB_DATA(wd), .ABS_A(abs_a), .ABS_B(abs_b), .ABS_C(abs_c),
		.ABS_VALID(abs_valid), .PROT_TRAP(prot_trap), .OPER_A_DATA(oa),
		.OPER_B_DATA(ob), .SPR_RDATA(srd), .SPR_TRAP(spr_trap));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic xl(input gpra_num_t a, input gpra_num_t b,
		input gpra_num_t c, input logic [2:0] u, input logic ld,
		input gpra_num_t ea, input gpra_num_t eb, input gpra_num_t ec,
		input logic et);
		pipe.issue(a, b, c, u, ld);
		#1;
		check(abs_valid, 1'h1);
		check({abs_a, abs_b, abs_c}, {ea, eb, ec});
		check(prot_trap, et);
	endtask
	task automatic sp(input logic rd, input gpra_num_t n, input gpra_word_t d,
		input logic et);
		pipe.spr(rd, n, d);
		#1;
		check(spr_trap, et);
	endtask
	task automatic mode(input logic s);
		@(posedge sys_clk);
		sup <= s;
	endtask
	initial
	begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#100000;
		fails++;
		stop_test();
	end
	initial
	begin : main
		gpra_num_t num;
		gpra_num_t nb;
		rst = 1'h1;
		ce = 1'h1;
		sup = 1'h1;
		fails = 0;
		cmp_count = 0;
		p = '{PTR_RESET, PTR_RESET, PTR_RESET};
		repeat (20) @(posedge sys_clk);
		rst <= 1'h0;
		sp(1'h1, SPR_BANK_MASK, WORD_ZERO, 1'h0);
		check(srd, {16'h0000, MASK_RESET});
		// shadow stack pointer is zero here, so locals map to themselves
		for (int n = 0; n < 16; n++)
		begin
			num = gpra_num_t'(n * 16 + 2);
			nb = gpra_num_t'(n * 16 - 1);
			mode(1'h1);
			sp(1'h0, SPR_BANK_MASK, 32'h0000_0001 << n, 1'h0);
			mode(1'h0);
			xl(num, nb, 8'h01, 3'h7, 1'h0, num, nb, 8'h01, 1'h1);
			xl(nb, 8'h01, nb, 3'h7, 1'h0, nb, 8'h01, nb, 1'h0);
			mode(1'h1);
			xl(num, num, num, 3'h7, 1'h0, num, num, num, 1'h0);
		end
		sp(1'h0, SPR_BANK_MASK, WORD_ZERO, 1'h0);
		pipe.wb(1'h0, 8'h45, 32'hA5A5_0001);
		pipe.wb(1'h0, 8'hC2, 32'h1234_5678);
		xl(8'h45, 8'hC2, 8'h05, 3'h7, 1'h0, 8'h45, 8'hC2, 8'h05, 1'h0);
		check({oa, ob}, 64'hA5A5_0001_1234_5678);
		pipe.wb(1'h1, SP_REG_NUM, 32'h0000_0104);
		xl(8'h80, 8'hFF, 8'h05, 3'h7, 1'h0, 8'hC1, 8'hC0, 8'h05, 1'h0);
		pipe.wb(1'h0, SP_REG_NUM, 32'h0000_0200);
		pipe.wb(1'h1, 8'h41, 32'h0000_0200);
		xl(8'h80, 8'hFF, 8'h05, 3'h7, 1'h0, 8'hC1, 8'hC0, 8'h05, 1'h0);
		sp(1'h0, SPR_BANK_MASK, 32'h0000_1000, 1'h0);
		mode(1'h0);
		xl(8'h80, 8'h8F, 8'h05, 3'h1, 1'h0, 8'hC1, 8'hD0, 8'h05, 1'h1);
		xl(8'h8F, 8'h80, 8'h05, 3'h1, 1'h0, 8'hD0, 8'hC1, 8'h05, 1'h0);
		xl(8'h8F, 8'h80, 8'h05, 3'h2, 1'h0, 8'hD0, 8'hC1, 8'h05, 1'h1);
		xl(8'h85, 8'h10, 8'h90, 3'h7, 1'h1, 8'hC6, 8'h10, 8'hD1, 1'h1);
		pipe.issue(8'h05, 8'h05, 8'h05, 3'h0, 1'h0);
		p = '{8'hC6, 8'h10, 8'hD1};
		xl(8'h00, 8'h00, 8'h00, 3'h0, 1'h0, p[0], p[1], p[2], 1'h0);
		for (int k = 0; k < 3; k++)
		begin
			num = 8'hC8 + gpra_num_t'(k);
			nb = (k == 0) ? SPR_PTR_A : (k == 1) ? SPR_PTR_B : SPR_PTR_C;
			sp(1'h0, nb, {22'h3F_FFFF, num, 2'h3}, 1'h0);
			xl(8'h00, 8'h00, 8'h00, 3'h0, 1'h0, p[0], p[1], p[2], 1'h0);
			p[k] = num;
			xl(8'h00, 8'h00, 8'h00, 3'h0, 1'h0, p[0], p[1], p[2], 1'h0);
			sp(1'h1, nb, WORD_ZERO, 1'h0);
			check(srd, {22'h00_0000, num, 2'h0});
		end
		sp(1'h0, SPR_BANK_MASK, 32'h0000_FFFF, 1'h1);
		sp(1'h1, SPR_BANK_MASK, WORD_ZERO, 1'h1);
		sp(1'h1, 8'hA0, WORD_ZERO, 1'h1);
		sp(1'h1, SPR_LAST_OPEN, WORD_ZERO, 1'h0);
		check(srd, WORD_ZERO);
		mode(1'h1);
		sp(1'h1, SPR_BANK_MASK, WORD_ZERO, 1'h0);
		check(srd, 32'h0000_1000);
		stop_test();
	end
endmodule // gpra_tb_top
